/* File: src/hrr_rx_end.sv */
// Behaviour
// - decrypt active pixels, present on video output
// - key exchange with upstream over back channel
// - device key kept inside, no read path
// - gather downstream vectors, forward list upstream
// - i2c master reads each transmitter slave
// - read status and vector of every transmitter
// - at most three transmitters, two levels
// - drive clear 24-bit rgb, syncs, pixel clock
// - blanking carries control and audio packets
// - optional separate i2s audio connection
// - transmitters re-encrypt the active pixels they accept, blanking passes clear
// - each device has a unique strapped address
// - repeater mode strap before repeater operation
// - transmitter interrupt wired to receiver input
// - transmitter video inputs wired to receiver
module hrr_rx_end import hrr_pkg::*; #(
  parameter int NUM_TX = MAX_TX,
  parameter int QTR_CYC = I2C_QTR_CYC,
  parameter logic [39:0] DEV_KSV = 40'h0f0f0f0f0f // arbitrary value
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_repeater_mode,
  input wire logic i_poll,
  input wire logic i_bc_stb,
  input wire logic [23:0] i_bc_an,
  input wire logic i_enc_stb,
  input wire logic [23:0] i_enc_rgb,
  input wire logic i_enc_de,
  input wire logic i_enc_vs,
  input wire logic i_enc_hs,
  input wire logic i_i2s_en,
  input wire logic i_i2s_bclk,
  input wire logic i_i2s_wc,
  input wire logic i_i2s_da,
  hrr_link_if.rx lnk,
  output logic o_authed,
  output logic o_bc_stb,
  output logic [39:0] o_bc_ksv,
  output logic o_ksv_stb,
  output logic [39:0] o_ksv_data,
  output logic o_list_done,
  output logic [1:0] o_ksv_count,
  output logic [NUM_TX-1:0][7:0] o_tx_status,
  output logic o_busy
);
  typedef enum logic [2:0] {
    M_IDLE, M_START, M_ADDR, M_AACK, M_RD, M_MACK, M_STOP, M_NEXT
  } hrr_mst_t;

  localparam int QW = $clog2(QTR_CYC + 1);
  // secret key: feeds only the seed, never any port
  localparam logic [23:0] DEV_KEY = 24'h5a3c96;

  // ---- authentication and cipher ----
  logic [23:0] ks_r; // running keystream
  wire dec_en = i_enc_de && o_authed; // blanking passes untouched

  // back-channel exchange seeds the cipher and answers our vector
  always_ff @(posedge i_clk_sys) begin
    o_bc_stb <= 1'b0;
    if (i_reset) begin
      o_authed <= 1'b0;
      ks_r <= 24'h000001;
      o_bc_ksv <= 40'h0;
    end else if (i_bc_stb) begin
      ks_r <= hrr_seed(DEV_KEY, i_bc_an);
      o_authed <= 1'b1;
      o_bc_stb <= 1'b1;
      o_bc_ksv <= DEV_KSV;
    end else if (i_enc_stb && dec_en) begin
      ks_r <= hrr_ks_step(ks_r);
    end
  end

  // ---- video and audio toward transmitters ----
  logic pclk_r;
  logic [23:0] rgb_r;
  logic [2:0] ctl_r;
  logic [2:0] i2s_r;
  // audio pins run on their own clock, two stages before use
  logic [2:0] i2s_a_r;
  logic [2:0] i2s_b_r;
  // data registered on the strobe, pclk rises in the same cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      pclk_r <= 1'b0;
      rgb_r <= 24'h000000;
      ctl_r <= 3'h0;
      i2s_r <= 3'h0;
    end else begin
      pclk_r <= i_enc_stb && !pclk_r;
      if (i_enc_stb) begin
        rgb_r <= i_enc_rgb ^ (dec_en ? ks_r : 24'h000000);
        ctl_r <= {i_enc_de, i_enc_vs, i_enc_hs};
      end
      // separate i2s path only when chosen, else held low
      i2s_r <= i_i2s_en ? i2s_b_r : 3'h0;
    end
  end
  assign lnk.pclk = pclk_r;
  assign lnk.rgb = rgb_r;
  assign {lnk.data_enable, lnk.vertical_sync, lnk.horizontal_sync} = ctl_r;
  assign {lnk.i2s_bclk, lnk.i2s_wc, lnk.i2s_da} = i2s_r;

  // ---- pin synchronisers ----
  logic [1:0] sda_s_r;
  logic [2:0] irq_s_r; // third stage is only for the edge
  always_ff @(posedge i_clk_sys) begin
    sda_s_r <= {sda_s_r[0], lnk.sda};
    irq_s_r <= {irq_s_r[1:0], lnk.irq_n};
    i2s_a_r <= {i_i2s_bclk, i_i2s_wc, i_i2s_da};
    i2s_b_r <= i2s_a_r;
  end
  wire sda_in = sda_s_r[1];
  wire irq_fall = !irq_s_r[1] && irq_s_r[2];

  // ---- quarter-bit tick ----
  logic [QW-1:0] qcnt_r;
  wire qt = (qcnt_r == QW'(QTR_CYC - 1));
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || qt) begin
      qcnt_r <= '0;
    end else begin
      qcnt_r <= qcnt_r + 1'b1;
    end
  end

  // ---- i2c master ----
  hrr_mst_t st_r;
  logic [1:0] ph_r; // quarter phase inside a bit
  logic [7:0] sh_r;
  logic [2:0] bit_r;
  logic [2:0] bidx_r;
  logic [1:0] idx_r; // transmitter being read
  logic ack_r;
  logic pend_r;
  logic [31:0] ksv_acc_r;
  logic scl_oe_r;
  logic sda_oe_r;

  wire ph_end = qt && (ph_r == 2'd3);
  wire in_bit = (st_r == M_ADDR) || (st_r == M_AACK) || (st_r == M_RD) || (st_r == M_MACK);
  wire more_w = (bidx_r != 3'(RD_BYTES - 1));
  wire last_tx = (idx_r == 2'(NUM_TX - 1));
  wire take = qt && (st_r == M_IDLE) && pend_r && i_repeater_mode;
  wire stat_auth = o_tx_status[idx_r][STAT_AUTH_BIT];
  // scl held low except the middle half of a bit
  wire scl_pull_w = in_bit ? (ph_r == 2'd0 || ph_r == 2'd3) :
                    (st_r == M_START) ? (ph_r >= 2'd2) :
                    (st_r == M_STOP) ? (ph_r == 2'd0) : 1'b0;
  wire sda_pull_w = (st_r == M_ADDR) ? !sh_r[7] :
                    (st_r == M_MACK) ? more_w :
                    (st_r == M_START) ? (ph_r >= 2'd1) :
                    (st_r == M_STOP) ? (ph_r <= 2'd1) : 1'b0;

  // event from transmitter interrupt or poll; set wins over take
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      pend_r <= 1'b0;
    end else begin
      pend_r <= (pend_r && !take) || irq_fall || i_poll;
    end
  end

  // registered pin drive
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      scl_oe_r <= scl_pull_w;
      sda_oe_r <= sda_pull_w;
    end
  end
  assign lnk.scl_m_o = 1'b0;
  assign lnk.scl_m_oe = scl_oe_r;
  assign lnk.sda_m_o = 1'b0;
  assign lnk.sda_m_oe = sda_oe_r;

  // phase counter runs while a frame is in flight
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || st_r == M_IDLE || st_r == M_NEXT) begin
      ph_r <= 2'd0;
    end else if (qt) begin
      ph_r <= ph_r + 2'd1;
    end
  end

  // read burst: address, status byte, vector bytes
  always_ff @(posedge i_clk_sys) begin
    o_ksv_stb <= 1'b0;
    o_list_done <= 1'b0;
    if (i_reset) begin
      st_r <= M_IDLE;
      sh_r <= 8'h00;
      bit_r <= 3'd0;
      bidx_r <= 3'd0;
      idx_r <= 2'd0;
      ack_r <= 1'b0;
      ksv_acc_r <= 32'h0;
      o_ksv_data <= 40'h0;
      o_ksv_count <= 2'd0;
      o_tx_status <= '0;
      o_busy <= 1'b0;
    end else begin
      case (st_r)
        M_IDLE: begin
          if (take) begin
            st_r <= M_START;
            idx_r <= 2'd0;
            o_ksv_count <= 2'd0;
            o_busy <= 1'b1;
          end
        end
        M_START: begin
          if (ph_end) begin
            st_r <= M_ADDR;
            sh_r <= {TX_ADDR_BASE + 7'(idx_r), 1'b1};
            bit_r <= 3'd7;
          end
        end
        M_ADDR: begin
          if (ph_end) begin
            sh_r <= {sh_r[6:0], 1'b0};
            bit_r <= bit_r - 3'd1;
            if (bit_r == 3'd0) begin
              st_r <= M_AACK;
            end
          end
        end
        M_AACK: begin
          if (qt && ph_r == 2'd2) begin
            ack_r <= !sda_in;
          end else if (ph_end) begin
            // absent transmitter answers nothing: skip it
            st_r <= ack_r ? M_RD : M_STOP;
            bit_r <= 3'd7;
            bidx_r <= 3'd0;
          end
        end
        M_RD: begin
          if (qt && ph_r == 2'd2) begin
            sh_r <= {sh_r[6:0], sda_in};
          end else if (ph_end) begin
            bit_r <= bit_r - 3'd1;
            if (bit_r == 3'd0) begin
              st_r <= M_MACK;
            end
          end
        end
        M_MACK: begin
          if (ph_end) begin
            if (bidx_r == 3'd0) begin
              o_tx_status[idx_r] <= sh_r;
            end else begin
              ksv_acc_r <= {ksv_acc_r[23:0], sh_r};
            end
            if (more_w) begin
              st_r <= M_RD;
              bit_r <= 3'd7;
              bidx_r <= bidx_r + 3'd1;
            end else begin
              st_r <= M_STOP;
              // only authenticated downstream links join the list
              if (stat_auth) begin
                o_ksv_stb <= 1'b1;
                o_ksv_data <= {ksv_acc_r, sh_r};
                o_ksv_count <= o_ksv_count + 2'd1;
              end
            end
          end
        end
        M_STOP: begin
          if (ph_end) begin
            st_r <= M_NEXT;
          end
        end
        M_NEXT: begin
          if (qt) begin
            if (last_tx) begin
              st_r <= M_IDLE;
              o_list_done <= 1'b1;
              o_busy <= 1'b0;
            end else begin
              idx_r <= idx_r + 2'd1;
              st_r <= M_START;
            end
          end
        end
        default: begin
          st_r <= M_IDLE;
        end
      endcase
    end
  end
endmodule

/* File: src/hrr_pkg.sv */
package hrr_pkg;
  // system clock
  localparam int CLK_PERIOD_NS = 4;
  // i2c bit time, split into four quarter phases
  localparam int I2C_BIT_NS = 10000;
  localparam int I2C_QTR_CYC = I2C_BIT_NS / 4 / CLK_PERIOD_NS;
  // topology limits
  localparam int MAX_TX = 3;
  localparam int MAX_LEVELS = 2;
  // first downstream transmitter address, the rest follow upward
  localparam logic [6:0] TX_ADDR_BASE = 7'h40;
  // status byte then key-selection vector, read in one burst
  localparam int KSV_BYTES = 5;
  localparam int RD_BYTES = KSV_BYTES + 1;
  // status byte fields
  localparam int STAT_AUTH_BIT = 0;
  localparam int STAT_EVENT_BIT = 1;
  localparam int STAT_RPT_BIT = 2;
  // keystream generator taps
  localparam logic [23:0] KS_TAPS = 24'he10000;
  // pixel-rate video word
  localparam int RGB_W = 24;

  // one keystream step per active pixel
  function automatic logic [23:0] hrr_ks_step(input logic [23:0] s);
    return {s[22:0], ^(s & KS_TAPS)};
  endfunction

  // session seed from a secret and the exchanged value
  function automatic logic [23:0] hrr_seed(input logic [23:0] k, input logic [23:0] an);
    return k ^ an ^ {an[11:0], an[23:12]} ^ 24'h000001;
  endfunction
endpackage

/* File: src/hrr_link_if.sv */
// receiver-to-transmitter link: video, i2c, i2s, interrupt
interface hrr_link_if;
  logic pclk;
  logic [23:0] rgb;
  logic data_enable;
  logic vertical_sync;
  logic horizontal_sync;
  logic i2s_bclk;
  logic i2s_wc;
  logic i2s_da;
  // open-drain drivers, value pins hold 0
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic irq_s_o;
  logic irq_s_oe;
  // resolved wires with pull-ups
  logic scl;
  logic sda;
  logic irq_n;

  assign scl = (scl_m_oe && !scl_m_o) ? 1'b0 : 1'b1;
  assign sda = ((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o)) ? 1'b0 : 1'b1;
  assign irq_n = (irq_s_oe && !irq_s_o) ? 1'b0 : 1'b1;

  modport rx (output pclk, rgb, data_enable, vertical_sync, horizontal_sync,
              i2s_bclk, i2s_wc, i2s_da, scl_m_o, scl_m_oe, sda_m_o, sda_m_oe,
              input scl, sda, irq_n);
  modport tx (input pclk, rgb, data_enable, vertical_sync, horizontal_sync,
              i2s_bclk, i2s_wc, i2s_da, scl, sda,
              output sda_s_o, sda_s_oe, irq_s_o, irq_s_oe);
endinterface

/* File: src/hrr_tx_end.sv */
// downstream transmitter end: i2c status slave, interrupt, re-encryption
module hrr_tx_end import hrr_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [6:0] i_address_strap_pin,
  input wire logic i_repeater_mode,
  input wire logic i_authed,
  input wire logic [39:0] i_ksv,
  input wire logic i_event,
  input wire logic [23:0] i_seed,
  hrr_link_if.tx lnk,
  output logic o_pix_stb,
  output logic [23:0] o_rgb,
  output logic o_data_enable,
  output logic o_vertical_sync,
  output logic o_horizontal_sync,
  output logic o_i2s_bclk,
  output logic o_i2s_wc,
  output logic o_i2s_da,
  output logic o_irq_pending
);
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_AACK, S_TX, S_MACK} hrr_sst_t;

  // two-stage synchronisers for every pin, third stage for edges
  logic [27:0] pin_a_r;
  logic [27:0] pin_b_r;
  logic [27:0] pin_c_r;
  // pclk on top, rgb below it, de/vs/hs in the low three bits
  wire [27:0] pin_w = {lnk.pclk, lnk.rgb, lnk.data_enable, lnk.vertical_sync,
                       lnk.horizontal_sync};
  logic [4:0] ctl_a_r;
  logic [4:0] ctl_b_r;
  logic [1:0] i2c_c_r; // previous scl, sda
  wire scl_w = ctl_b_r[4];
  wire sda_w = ctl_b_r[3];
  wire scl_rise = scl_w && !i2c_c_r[1];
  wire scl_fall = !scl_w && i2c_c_r[1];
  wire start_w = scl_w && i2c_c_r[1] && !sda_w && i2c_c_r[0];
  wire stop_w = scl_w && i2c_c_r[1] && sda_w && !i2c_c_r[0];
  wire pclk_rise = pin_b_r[27] && !pin_c_r[27];

  always_ff @(posedge i_clk_sys) begin
    pin_a_r <= pin_w;
    pin_b_r <= pin_a_r;
    pin_c_r <= pin_b_r;
    ctl_a_r <= {lnk.scl, lnk.sda, lnk.i2s_bclk, lnk.i2s_wc, lnk.i2s_da};
    ctl_b_r <= ctl_a_r;
    i2c_c_r <= ctl_b_r[4:3];
  end

  // address strap caught once reset releases
  logic [6:0] my_addr_r;
  logic rpt_r;
  logic strap_done_r;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      my_addr_r <= i_address_strap_pin;
      rpt_r <= i_repeater_mode;
      strap_done_r <= 1'b1;
    end
  end

  // status byte and read data by byte index
  wire [7:0] stat_w = {5'h00, rpt_r, o_irq_pending, i_authed};
  logic [2:0] bidx_r;
  wire [7:0] rd_byte_w = (bidx_r == 3'd0) ? stat_w :
                         (bidx_r <= 3'(KSV_BYTES)) ? i_ksv[(KSV_BYTES - bidx_r) * 8 +: 8] :
                         8'h00;

  // slave sequencer: sample on scl rise, change sda on scl fall
  hrr_sst_t st_r;
  logic [7:0] sh_r;
  logic [3:0] cnt_r;
  logic sda_oe_r;
  logic stat_read_r; // one-cycle: status byte acked or nacked
  always_ff @(posedge i_clk_sys) begin
    stat_read_r <= 1'b0;
    if (i_reset) begin
      st_r <= S_IDLE;
      sda_oe_r <= 1'b0;
      cnt_r <= 4'h0;
      bidx_r <= 3'h0;
      sh_r <= 8'h00;
    end else if (start_w) begin
      st_r <= S_ADDR; // any start restarts the frame
      cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
    end else if (stop_w) begin
      st_r <= S_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      case (st_r)
        S_ADDR: begin
          if (scl_rise) begin
            sh_r <= {sh_r[6:0], sda_w};
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == 4'd8) begin
            // answer only reads to our own address, in repeater mode
            if (sh_r == {my_addr_r, 1'b1} && rpt_r) begin
              st_r <= S_AACK;
              sda_oe_r <= 1'b1;
            end else begin
              st_r <= S_IDLE;
            end
          end
        end
        S_AACK: begin
          if (scl_fall) begin
            st_r <= S_TX;
            bidx_r <= 3'h0;
            sh_r <= stat_w;
            cnt_r <= 4'h0;
            sda_oe_r <= !stat_w[7];
          end
        end
        S_TX: begin
          if (scl_fall) begin
            if (cnt_r == 4'd7) begin
              st_r <= S_MACK;
              sda_oe_r <= 1'b0;
            end else begin
              sh_r <= {sh_r[6:0], 1'b0};
              cnt_r <= cnt_r + 4'h1;
              sda_oe_r <= !sh_r[6];
            end
          end
        end
        S_MACK: begin
          if (scl_rise) begin
            stat_read_r <= (bidx_r == 3'h0);
            if (sda_w) begin
              st_r <= S_IDLE; // master nack ends the burst
            end else begin
              bidx_r <= bidx_r + 3'h1;
            end
          end else if (scl_fall) begin
            st_r <= S_TX;
            sh_r <= rd_byte_w;
            cnt_r <= 4'h0;
            sda_oe_r <= !rd_byte_w[7];
          end
        end
        default: begin
          st_r <= S_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end
  assign lnk.sda_s_o = 1'b0;
  assign lnk.sda_s_oe = sda_oe_r;

  // interrupt: set wins over the clear done by a status read
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_irq_pending <= 1'b0;
    end else begin
      o_irq_pending <= (o_irq_pending && !stat_read_r) || i_event;
    end
  end
  assign lnk.irq_s_o = 1'b0;
  assign lnk.irq_s_oe = o_irq_pending;

  // capture pixels on pclk rise, re-encrypt active ones
  logic [23:0] ks_r;
  always_ff @(posedge i_clk_sys) begin
    o_pix_stb <= 1'b0;
    if (i_reset) begin
      ks_r <= 24'h000001;
      o_rgb <= 24'h000000;
      {o_data_enable, o_vertical_sync, o_horizontal_sync} <= 3'h0;
      {o_i2s_bclk, o_i2s_wc, o_i2s_da} <= 3'h0;
    end else begin
      {o_i2s_bclk, o_i2s_wc, o_i2s_da} <= ctl_b_r[2:0];
      if (i_event) begin
        ks_r <= hrr_seed(i_seed, i_seed);
      end
      if (pclk_rise) begin
        o_pix_stb <= 1'b1;
        o_rgb <= pin_b_r[26:3] ^ (pin_b_r[2] ? ks_r : 24'h000000);
        {o_data_enable, o_vertical_sync, o_horizontal_sync} <= pin_b_r[2:0];
        if (pin_b_r[2] && !i_event) begin
          ks_r <= hrr_ks_step(ks_r);
        end
      end
    end
  end
endmodule

/* File: verif/hrr_link_properties.sv */
// watches the receiver-to-transmitter link from beside the interface
module hrr_link_properties #(
  parameter int QTR_CYC = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic pclk,
  input wire logic [23:0] rgb,
  input wire logic data_enable,
  input wire logic vertical_sync,
  input wire logic horizontal_sync,
  input wire logic scl_m_o,
  input wire logic scl_m_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic irq_s_o,
  input wire logic irq_s_oe,
  input wire logic scl,
  input wire logic irq_n
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int QLO = QTR_CYC - 1; // start edge spacing window
  localparam int QHI = QTR_CYC + 1;
  localparam int MIN_RUN = 2 * QTR_CYC; // shortest scl level is two quarters
  localparam int SCAN_WAIT = 16 * QTR_CYC; // 2ff, tick wait and start
  int run_r; // cycles since scl drive last moved

  // run length of the scl drive; a short run means a bad quarter count
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || $changed(scl_m_oe)) begin
      run_r <= 1;
    end else begin
      run_r <= run_r + 1;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  a_pclk_pulse: assert property (pclk |=> !pclk)
    else $error("pixel clock high for more than one cycle");
  a_video_hold: assert property (
    $changed({rgb, data_enable, vertical_sync, horizontal_sync}) |-> pclk)
    else $error("video changed without a pixel clock");
  a_open_drain: assert property (!scl_m_o && !sda_m_o && !sda_s_o && !irq_s_o)
    else $error("open drain value pin not low");
  a_scl_run: assert property ($changed(scl_m_oe) |-> run_r >= MIN_RUN)
    else $error("scl level shorter than two quarters");
  a_start_order: assert property (
    $rose(sda_m_oe) && !scl_m_oe |-> ##[QLO:QHI] scl_m_oe)
    else $error("start condition without scl low one quarter later");
  a_slave_sda_low: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("slave moved sda while scl high");
  a_irq_clear: assert property ($fell(irq_s_oe) |-> scl)
    else $error("interrupt cleared outside an scl high phase");
  a_irq_scan: assert property ($fell(irq_n) |-> ##[1:SCAN_WAIT] scl_m_oe)
    else $error("interrupt did not start a status scan");
endmodule

/* File: verif/tb_hdcp_receiver_repeater_control.sv */
// one receiver, one transmitter at index 0, index 1 left empty
module tb_hdcp_receiver_repeater_control import hrr_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int QTR = 4; // short quarter keeps scans brief
  localparam logic [23:0] KEY = 24'h5a3c96; // receiver session secret
  localparam logic [39:0] DEV_KSV = 40'h3c3c3c3c3c; // arbitrary value
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic rpt = 1'b0, poll = 1'b0, bc_stb = 1'b0, enc_stb = 1'b0;
  logic enc_de = 1'b0, enc_vs = 1'b0, enc_hs = 1'b0;
  logic i2s_en = 1'b0, bclk = 1'b0, wc = 1'b0, da = 1'b0;
  logic tx_authed = 1'b0, tx_event = 1'b0, tx_rpt = 1'b1;
  logic [23:0] bc_an = 24'h0, enc_rgb = 24'h0, tx_seed = 24'h1;
  logic [39:0] tx_ksv = 40'h0;
  logic authed, bco_stb, ksv_stb, list_done, busy, pix_stb, t_de, t_vs, t_hs;
  logic t_bclk, t_wc, t_da, irq_pend;
  logic [39:0] bco_ksv, ksv_data;
  logic [1:0] ksv_count;
  logic [1:0][7:0] tx_status;
  logic [23:0] t_rgb;
  logic [23:0] ks = 24'h0; // model keystream
  bit m_auth = 1'b0; // model session state
  logic [27:0] exp_q[$]; // expected pixels {pclk, de, vs, hs, rgb}
  int fail_count = 0;
  int comparisons = 0;
  int i;

  always #2 i_clk_sys = ~i_clk_sys;
  // audio bit clock runs only while audio is enabled
  always #80 if (i2s_en) bclk = ~bclk;

  hrr_link_if lnk ();
  hrr_rx_end #(.NUM_TX(2), .QTR_CYC(QTR), .DEV_KSV(DEV_KSV)) hrr_rx_end_inst (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_repeater_mode(rpt), .i_poll(poll),
    .i_bc_stb(bc_stb), .i_bc_an(bc_an), .i_enc_stb(enc_stb), .i_enc_rgb(enc_rgb),
    .i_enc_de(enc_de), .i_enc_vs(enc_vs), .i_enc_hs(enc_hs), .i_i2s_en(i2s_en),
    .i_i2s_bclk(bclk), .i_i2s_wc(wc), .i_i2s_da(da), .lnk(lnk), .o_authed(authed),
    .o_bc_stb(bco_stb), .o_bc_ksv(bco_ksv), .o_ksv_stb(ksv_stb), .o_ksv_data(ksv_data),
    .o_list_done(list_done), .o_ksv_count(ksv_count), .o_tx_status(tx_status),
    .o_busy(busy));
  // strapped to the first downstream address, repeater mode on
  hrr_tx_end hrr_tx_end_inst (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_address_strap_pin(TX_ADDR_BASE),
    .i_repeater_mode(tx_rpt), .i_authed(tx_authed), .i_ksv(tx_ksv), .i_event(tx_event),
    .i_seed(tx_seed), .lnk(lnk), .o_pix_stb(pix_stb), .o_rgb(t_rgb),
    .o_data_enable(t_de), .o_vertical_sync(t_vs), .o_horizontal_sync(t_hs),
    .o_i2s_bclk(t_bclk), .o_i2s_wc(t_wc), .o_i2s_da(t_da), .o_irq_pending(irq_pend));
  hrr_link_properties #(.QTR_CYC(QTR)) hrr_link_properties_inst (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .pclk(lnk.pclk), .rgb(lnk.rgb),
    .data_enable(lnk.data_enable), .vertical_sync(lnk.vertical_sync),
    .horizontal_sync(lnk.horizontal_sync), .scl_m_o(lnk.scl_m_o), .scl_m_oe(lnk.scl_m_oe),
    .sda_m_o(lnk.sda_m_o), .sda_m_oe(lnk.sda_m_oe), .sda_s_o(lnk.sda_s_o),
    .sda_s_oe(lnk.sda_s_oe), .irq_s_o(lnk.irq_s_o), .irq_s_oe(lnk.irq_s_oe),
    .scl(lnk.scl), .irq_n(lnk.irq_n));

  // plain value comparison
  task automatic chk_val(input string what, input logic [39:0] exp, input logic [39:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // pixel comparison against the model queue
  task automatic chk_pix(input string what, input logic [27:0] exp, input logic [27:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // upstream exchange; the model reseeds its keystream from the value sent
  task automatic exchange(input logic [23:0] an);
    @(posedge i_clk_sys);
    bc_stb <= 1'b1;
    bc_an <= an;
    @(posedge i_clk_sys);
    bc_stb <= 1'b0;
    #1;
    chk_val("bc answer", {1'b1, DEV_KSV[38:0]}, {bco_stb & authed, bco_ksv[38:0]});
    chk_val("bc vector top", {39'd0, DEV_KSV[39]}, {39'd0, bco_ksv[39]});
    ks = KEY ^ an ^ {an[11:0], an[23:12]} ^ 24'h000001;
    m_auth = 1'b1;
    @(posedge i_clk_sys);
    #1;
    chk_val("bc strobe end", 40'd0, {39'd0, bco_stb});
  endtask

  // one pixel through the receiver and on into the transmitter
  task automatic send_pix(input logic d);
    logic [27:0] e;
    logic [23:0] r;
    logic v, h;
    int n;
    r = 24'($urandom);
    v = 1'($urandom);
    h = 1'($urandom);
    exp_q.push_back({1'b1, d, v, h, (d && m_auth) ? r ^ ks : r});
    // blanking pixels carry control and audio untouched and do not step
    if (d && m_auth) ks = {ks[22:0], ^(ks & KS_TAPS)};
    @(posedge i_clk_sys);
    enc_stb <= 1'b1;
    enc_rgb <= r;
    enc_de <= d;
    enc_vs <= v;
    enc_hs <= h;
    @(posedge i_clk_sys);
    enc_stb <= 1'b0;
    #1;
    e = exp_q.pop_front();
    chk_pix("link pixel", e, {lnk.pclk, lnk.data_enable, lnk.vertical_sync,
      lnk.horizontal_sync, lnk.rgb});
    for (n = 0; n < 8 && pix_stb !== 1'b1; n++) begin
      @(posedge i_clk_sys);
      #1;
    end
    chk_val("tx controls", {36'd0, e[27:24]}, {36'd0, pix_stb, t_de, t_vs, t_hs});
    chk_val("tx data in clear", {39'd0, ~d}, {39'd0, t_rgb === e[23:0]});
  endtask

  // one status scan, started by poll or by a transmitter event
  // tx_on low: the transmitter's strap is off, so it must not answer
  task automatic scan(input logic use_irq, input logic auth, input logic tx_on);
    logic [39:0] k, kv;
    int n;
    k = {8'($urandom), $urandom};
    kv = 40'd0;
    @(posedge i_clk_sys);
    tx_authed <= auth;
    tx_ksv <= k;
    tx_seed <= 24'($urandom) | 24'h000001;
    if (use_irq) tx_event <= 1'b1;
    else poll <= 1'b1;
    @(posedge i_clk_sys);
    tx_event <= 1'b0;
    poll <= 1'b0;
    for (n = 0; n < 6000 && list_done !== 1'b1; n++) begin
      @(posedge i_clk_sys);
      #1;
      if (ksv_stb === 1'b1) kv = ksv_data;
    end
    chk_val("list done", 40'd1, {39'd0, list_done});
    chk_val("tx status", tx_on ? {36'd0, 2'b01, use_irq, auth} : 40'd0,
      {32'd0, tx_status[0]});
    chk_val("forwarded vector", (auth && tx_on) ? k : 40'd0, kv);
    if (auth && tx_on) chk_val("vector count", 40'd1, {38'd0, ksv_count});
    chk_val("irq pending", 40'd0, {39'd0, irq_pend});
  endtask

  // hang guard, far beyond the expected run length
  initial begin
    #120000;
    fail_count++;
    final_report();
  end

  initial begin
    logic seen;
    void'($urandom(32'h8c8d));
    repeat (12) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    rpt <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    scan(1'b0, 1'b0, 1'b1);
    scan(1'b1, 1'b1, 1'b1);
    scan(1'b0, 1'b1, 1'b1);
    // before the exchange every pixel passes the receiver unchanged
    for (i = 0; i < 4; i++) send_pix(i[0]);
    exchange(24'($urandom));
    exchange(24'($urandom));
    for (i = 0; i < 16; i++) send_pix(1'($urandom));
    // separate audio path copied through both ends
    @(posedge i_clk_sys);
    i2s_en <= 1'b1;
    for (i = 0; i < 4; i++) begin
      @(posedge i_clk_sys);
      wc <= 1'($urandom);
      da <= 1'($urandom);
      repeat (6) @(posedge i_clk_sys);
      #1;
      chk_val("i2s link", {38'd0, wc, da}, {38'd0, lnk.i2s_wc, lnk.i2s_da});
      chk_val("i2s tx", {38'd0, wc, da}, {38'd0, t_wc, t_da});
    end
    @(posedge i_clk_sys);
    i2s_en <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    #1;
    chk_val("i2s off", 40'd0, {37'd0, lnk.i2s_bclk, lnk.i2s_wc, lnk.i2s_da});
    repeat (3) @(posedge i_clk_sys);
    #1;
    chk_val("i2s tx off", 40'd0, {37'd0, t_bclk, t_wc, t_da});
    // mid-run reset; the transmitter comes back with its repeater strap off
    @(posedge i_clk_sys);
    i_reset <= 1'b1;
    tx_rpt <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    m_auth = 1'b0;
    repeat (2) @(posedge i_clk_sys);
    #1;
    chk_val("authed after reset", 40'd0, {39'd0, authed});
    scan(1'b0, 1'b1, 1'b0);
    // without the repeater strap a poll must not start a scan
    @(posedge i_clk_sys);
    rpt <= 1'b0;
    @(posedge i_clk_sys);
    poll <= 1'b1;
    @(posedge i_clk_sys);
    poll <= 1'b0;
    seen = 1'b0;
    repeat (60) begin
      @(posedge i_clk_sys);
      #1;
      seen = seen | (busy !== 1'b0) | (list_done !== 1'b0);
    end
    chk_val("scan while strap off", 40'd0, {39'd0, seen});
    final_report();
  end
endmodule
